// ==== etc_consts.svh ====
// register offsets, field positions, reset values and timing counts for the exposure trigger block
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
`define ETC_ADDR_W 4
`define ETC_OFS_CTRL 4'h0
`define ETC_OFS_EXPOSURE 4'h1
`define ETC_OFS_READOUT 4'h2
`define ETC_OFS_FRAMES 4'h3
`define ETC_OFS_STATUS 4'h4
`define ETC_OFS_COUNT 4'h5
`define ETC_CTRL_MODE_LO 0
`define ETC_CTRL_MODE_HI 1
`define ETC_CTRL_POL_BIT 2
`define ETC_CTRL_CAPTURE_BIT 3
`define ETC_CTRL_RESET 32'h0000_0000
`define ETC_EXPOSURE_RESET 32'h0000_0064
`define ETC_READOUT_RESET 32'h0000_0064
`define ETC_FRAMES_RESET 32'h0000_0001
`define ETC_UNMAPPED_DATA 32'h0000_0000
`define ETC_ASYNC_FRAMES 32'h0000_0001
`define ETC_CNT_ONE 32'h0000_0001
`define ETC_CNT_ZERO 32'h0000_0000
`endif

// ==== etc_pkg.sv ====
// types shared by the exposure trigger block
package etc_pkg;
   typedef enum logic [1:0] {
      ETC_TRIG_NONE = 2'b00,
      ETC_TRIG_STANDARD = 2'b01,
      ETC_TRIG_PULSE_TIMED = 2'b10
   } etc_trig_mode_t;
   typedef enum logic [1:0] {
      ETC_ST_IDLE = 2'b00,
      ETC_ST_EXPOSE = 2'b01,
      ETC_ST_READOUT = 2'b10
   } etc_state_t;
endpackage

// ==== etc_sync.sv ====
// two-flop synchroniser for the trigger pin
`timescale 1ns/100ps
module etc_sync (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic async_in, // pin level from outside the clock domain
   output logic sync_out // level safe to read in core_clk domain
);
   logic meta_q;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         meta_q <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== etc_timer.sv ====
// down counter that reports when a programmed duration has elapsed
`timescale 1ns/100ps
module etc_timer #(
   parameter int WIDTH = 32
) (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic start, // load the duration and begin counting
   input wire logic [WIDTH-1:0] duration, // duration in clock cycles
   output logic done // one-cycle pulse in the last cycle of the duration
);
   logic [WIDTH-1:0] count_q;
   logic run_q;
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_q <= '0;
         run_q <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         // done leads by one cycle so a stage that ends on it lasts exactly the duration;
         // a zero duration still lasts one cycle
         count_q <= (duration == '0) ? '0 : duration - WIDTH'(1);
         run_q <= (duration > WIDTH'(1));
         done <= (duration <= WIDTH'(1));
      end else if (run_q) begin
         count_q <= count_q - WIDTH'(1);
         done <= (count_q == WIDTH'(1));
         run_q <= (count_q != WIDTH'(1));
      end else begin
         done <= 1'b0;
      end
   end
endmodule

// ==== etc_exposure_ctrl.sv ====
// exposure trigger controller with Avalon-MM register slave
`timescale 1ns/100ps
`include "etc_consts.svh"
module etc_exposure_ctrl #(
   parameter int CNT_W = 32
) (
   input wire logic core_clk, // system clock, 100 MHz
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [`ETC_ADDR_W-1:0] avs_address, // word address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // high until the access is answered
   input wire logic trigger_in, // external trigger pin
   output logic exposure_out, // high during exposure
   output logic readout_out // high while a frame is read out
);
   logic trig_s;
   logic trig_prev_q;
   logic [31:0] ctrl_q;
   logic [31:0] exposure_q;
   logic [31:0] readout_q;
   logic [31:0] frames_q;
   logic [31:0] frame_count_q;
   logic capture_q;
   logic ack_q;
   etc_pkg::etc_state_t exp_state_q;
   logic ro_busy_q;
   logic streaming_q;
   logic [31:0] capture_left_q;
   logic exp_start;
   logic exp_end;
   logic exp_timer_done;
   logic ro_timer_done;
   logic ro_start;
   logic trig_level;
   logic trig_assert;
   logic trig_deassert;
   etc_pkg::etc_trig_mode_t mode;
   logic async_mode;
   logic acc_wr;
   logic acc_rd;
   logic wr_done;

   etc_sync u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .async_in(trigger_in),
      .sync_out(trig_s)
   );

   etc_timer #(.WIDTH(CNT_W)) u_exp_timer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .start(exp_start),
      .duration(exposure_q[CNT_W-1:0]),
      .done(exp_timer_done)
   );

   etc_timer #(.WIDTH(CNT_W)) u_ro_timer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .start(ro_start),
      .duration(readout_q[CNT_W-1:0]),
      .done(ro_timer_done)
   );

   // trigger polarity and edge detection on the synchronised level
   assign trig_level = ctrl_q[`ETC_CTRL_POL_BIT] ? trig_s : !trig_s;
   assign trig_assert = trig_level && !trig_prev_q;
   assign trig_deassert = !trig_level && trig_prev_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         trig_prev_q <= 1'b0;
      end else begin
         trig_prev_q <= trig_level;
      end
   end

   // readout rate, binning, gain and offset never reach this logic
   assign mode = etc_pkg::etc_trig_mode_t'(ctrl_q[`ETC_CTRL_MODE_HI:`ETC_CTRL_MODE_LO]);
   assign async_mode = (frames_q == `ETC_ASYNC_FRAMES);

   // decide when an exposure starts and ends
   always_comb begin
      exp_start = 1'b0;
      exp_end = 1'b0;
      if (exp_state_q == etc_pkg::ETC_ST_IDLE) begin
         unique case (mode)
            etc_pkg::ETC_TRIG_NONE: begin
               exp_start = (capture_left_q != `ETC_CNT_ZERO) && !ro_busy_q;
            end
            etc_pkg::ETC_TRIG_STANDARD: begin
               if (async_mode) begin
                  // no start while reading out: the trigger is dropped
                  exp_start = trig_assert && !ro_busy_q;
               end else begin
                  exp_start = trig_assert || streaming_q;
               end
            end
            etc_pkg::ETC_TRIG_PULSE_TIMED: begin
               exp_start = trig_assert && !ro_busy_q;
            end
            default: begin
               exp_start = 1'b0;
            end
         endcase
      end else if (exp_state_q == etc_pkg::ETC_ST_EXPOSE) begin
         if (mode == etc_pkg::ETC_TRIG_PULSE_TIMED) begin
            exp_end = trig_deassert;
         end else begin
            exp_end = exp_timer_done;
         end
      end
   end

   // streaming may begin a new exposure while the previous frame reads out; a frame that
   // ends before the prior readout finishes restarts the readout timer (overlap limit)
   assign ro_start = exp_end;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         exp_state_q <= etc_pkg::ETC_ST_IDLE;
      end else if (exp_start) begin
         exp_state_q <= etc_pkg::ETC_ST_EXPOSE;
      end else if (exp_end) begin
         exp_state_q <= etc_pkg::ETC_ST_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ro_busy_q <= 1'b0;
      end else if (ro_start) begin
         ro_busy_q <= 1'b1;
      end else if (ro_timer_done) begin
         ro_busy_q <= 1'b0;
      end
   end

   // streaming runs from the first trigger until the mode leaves streaming
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         streaming_q <= 1'b0;
      end else if (mode != etc_pkg::ETC_TRIG_STANDARD || async_mode) begin
         streaming_q <= 1'b0;
      end else if (trig_assert) begin
         streaming_q <= 1'b1;
      end
   end

   // capture command loads the frame count when no hardware trigger is used
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         capture_left_q <= `ETC_CNT_ZERO;
      end else if (mode != etc_pkg::ETC_TRIG_NONE) begin
         capture_left_q <= `ETC_CNT_ZERO;
      end else if (capture_q) begin
         capture_left_q <= frames_q;
      end else if (exp_start) begin
         capture_left_q <= capture_left_q - `ETC_CNT_ONE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         exposure_out <= 1'b0;
         readout_out <= 1'b0;
      end else begin
         exposure_out <= exp_start || (exp_state_q == etc_pkg::ETC_ST_EXPOSE && !exp_end);
         readout_out <= ro_start || (ro_busy_q && !ro_timer_done);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         frame_count_q <= `ETC_CNT_ZERO;
      end else if (exp_end) begin
         frame_count_q <= frame_count_q + `ETC_CNT_ONE;
      end
   end

   // avalon slave: every access answered one cycle after it is seen
   assign acc_wr = avs_write && !ack_q;
   assign acc_rd = avs_read && !ack_q;
   // a write lands only at the edge where the master sees waitrequest low
   assign wr_done = avs_write && !avs_waitrequest;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         ack_q <= (acc_wr || acc_rd);
         avs_waitrequest <= !(acc_wr || acc_rd);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl_q <= `ETC_CTRL_RESET;
         exposure_q <= `ETC_EXPOSURE_RESET;
         readout_q <= `ETC_READOUT_RESET;
         frames_q <= `ETC_FRAMES_RESET;
         capture_q <= 1'b0;
      end else begin
         capture_q <= 1'b0;
         if (wr_done) begin
            unique case (avs_address)
               `ETC_OFS_CTRL: begin
                  ctrl_q <= {29'h0000_0000, avs_writedata[`ETC_CTRL_POL_BIT:0]};
                  capture_q <= avs_writedata[`ETC_CTRL_CAPTURE_BIT];
               end
               `ETC_OFS_EXPOSURE: exposure_q <= avs_writedata;
               `ETC_OFS_READOUT: readout_q <= avs_writedata;
               `ETC_OFS_FRAMES: frames_q <= avs_writedata;
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         avs_readdata <= `ETC_UNMAPPED_DATA;
      end else if (acc_rd) begin
         unique case (avs_address)
            `ETC_OFS_CTRL: avs_readdata <= ctrl_q;
            `ETC_OFS_EXPOSURE: avs_readdata <= exposure_q;
            `ETC_OFS_READOUT: avs_readdata <= readout_q;
            `ETC_OFS_FRAMES: avs_readdata <= frames_q;
            `ETC_OFS_STATUS: avs_readdata <= {28'h000_0000, streaming_q, trig_level,
                                              ro_busy_q, exp_state_q == etc_pkg::ETC_ST_EXPOSE};
            `ETC_OFS_COUNT: avs_readdata <= frame_count_q;
            default: avs_readdata <= `ETC_UNMAPPED_DATA;
         endcase
      end
   end
endmodule

// ==== etc_trig_src.sv ====
// trigger source model that drives the external trigger pin
`timescale 1ns/100ps
module etc_trig_src (
   input wire logic core_clk, // system clock
   output logic trigger_pin // external trigger pin
);
   logic idle_lvl = 1'h1;
   initial trigger_pin = 1'h1;
   // the pin is held for exactly n cycles, since in bulb mode that width is the exposure
   task automatic pulse(input int n);
      trigger_pin <= !idle_lvl;
      repeat (n) @(posedge core_clk);
      trigger_pin <= idle_lvl;
   endtask
   task automatic park(input logic lvl);
      idle_lvl = lvl;
      trigger_pin <= lvl;
   endtask
endmodule

// ==== etc_exposure_ctrl_props.sv ====
// assertions on the exposure trigger controller ports
`timescale 1ns/100ps
`include "etc_consts.svh"
module etc_exposure_ctrl_props #(
   parameter int CNT_W = 32
) (
   input wire logic core_clk, // clock
   input wire logic reset_n, // reset
   input wire logic [`ETC_ADDR_W-1:0] avs_address, // address
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic [31:0] avs_writedata, // wdata
   input wire logic [31:0] avs_readdata, // rdata
   input wire logic avs_waitrequest, // wait
   input wire logic trigger_in, // pin
   input wire logic exposure_out, // exposing
   input wire logic readout_out // reading
);
   logic [1:0] mode_q;
   logic pol_q;
   logic [31:0] frames_q;
   logic [31:0] exp_q;
   logic [31:0] cnt_q;
   logic act;
   logic single;
   logic bulb;
   logic strm;
   // shadow of the writes, so each check knows the mode in force
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode_q <= 2'h0;
         pol_q <= 1'h0;
         frames_q <= `ETC_FRAMES_RESET;
         exp_q <= `ETC_EXPOSURE_RESET;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == `ETC_OFS_CTRL) begin
            mode_q <= avs_writedata[1:0];
            pol_q <= avs_writedata[`ETC_CTRL_POL_BIT];
         end
         if (avs_address == `ETC_OFS_FRAMES) frames_q <= avs_writedata;
         if (avs_address == `ETC_OFS_EXPOSURE) exp_q <= avs_writedata;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n || !exposure_out) cnt_q <= 32'h0;
      else cnt_q <= cnt_q + 32'h1;
   end
   assign act = pol_q ? trigger_in : !trigger_in;
   assign single = mode_q == etc_pkg::ETC_TRIG_STANDARD && frames_q == `ETC_ASYNC_FRAMES;
   assign strm = mode_q == etc_pkg::ETC_TRIG_STANDARD && frames_q != `ETC_ASYNC_FRAMES;
   assign bulb = mode_q == etc_pkg::ETC_TRIG_PULSE_TIMED;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_idle_edge;
      (single || bulb) && $rose(act) && !exposure_out && !readout_out;
   endsequence
   // the edge must land early enough in readout to clear the pin synchroniser
   sequence s_busy_edge;
      (single || bulb) && $rose(act) && readout_out ##1 readout_out [*5];
   endsequence
   property p_start;
      s_idle_edge |-> ##[2:6] exposure_out;
   endproperty
   a_start: assert property (p_start) else $error("no exposure after trigger");
   property p_ignore;
      s_busy_edge |=> !exposure_out [*8];
   endproperty
   a_ignore: assert property (p_ignore) else $error("trigger taken in readout");
   property p_bulb_hold;
      (bulb && exposure_out && act) [*6] |=> exposure_out;
   endproperty
   a_bulb_hold: assert property (p_bulb_hold) else $error("bulb ended early");
   property p_bulb_end;
      (bulb && !act) [*6] |-> !exposure_out;
   endproperty
   a_bulb_end: assert property (p_bulb_end) else $error("bulb ran on");
   property p_len;
      single && $fell(exposure_out) |-> cnt_q == (exp_q == 32'h0 ? 32'h1 : exp_q);
   endproperty
   a_len: assert property (p_len) else $error("exposure length wrong");
   property p_follow;
      (single || bulb) && $fell(exposure_out) |-> ##[0:1] readout_out;
   endproperty
   a_follow: assert property (p_follow) else $error("no readout after exposure");
   property p_overlap;
      strm && $rose(readout_out) |-> ##[0:1] exposure_out;
   endproperty
   a_overlap: assert property (p_overlap) else $error("no overlapped exposure");
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_answer;
      $rose(avs_read || avs_write) |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");
endmodule
bind etc_exposure_ctrl etc_exposure_ctrl_props #(.CNT_W(CNT_W)) etc_exposure_ctrl_props_i (
   .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in), .exposure_out(exposure_out),
   .readout_out(readout_out));

// ==== exposure_trigger_control_test.sv ====
// self-checking bench for the exposure trigger controller
`timescale 1ns/100ps
`include "etc_consts.svh"
module exposure_trigger_control_test;
   typedef struct packed {logic [3:0] a; logic w; logic [31:0] d; logic [31:0] e;} etc_row_t;
   logic core_clk = 1'h0;
   logic reset_n;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic trigger_in;
   logic exposure_out;
   logic readout_out;
   logic [31:0] q;
   logic [31:0] c0;
   logic seen;
   int len;
   int fail_count = 0;
   int checks_done = 0;
   // reset values, read-only and unmapped places, then the timing used below
   etc_row_t rows [10] = '{'{4'h0, 1'h0, 32'h0, 32'h0}, '{4'h1, 1'h0, 32'h0, 32'h64},
      '{4'h2, 1'h0, 32'h0, 32'h64}, '{4'h3, 1'h0, 32'h0, 32'h1}, '{4'h4, 1'h0, 32'h0, 32'h0},
      '{4'h5, 1'h0, 32'h0, 32'h0}, '{4'hF, 1'h1, 32'hFF, 32'h0}, '{4'h4, 1'h1, 32'hF, 32'h0},
      '{4'h1, 1'h1, 32'h8, 32'h8}, '{4'h2, 1'h1, 32'h14, 32'h14}};
   always #5 core_clk = !core_clk;
   etc_exposure_ctrl etc_exposure_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .trigger_in(trigger_in),
      .exposure_out(exposure_out), .readout_out(readout_out));
   etc_trig_src etc_trig_src_i (.core_clk(core_clk), .trigger_pin(trigger_in));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      r = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (n >= 50) fail_count++;
   endtask
   // counts the cycles of the next exposure, values as sampled at each edge
   task automatic expo(output int n);
      int w;
      w = 0;
      n = 0;
      while (exposure_out !== 1'h1 && w < 100) begin
         @(posedge core_clk);
         w++;
      end
      while (exposure_out === 1'h1 && n < 300) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic quiet(input int n, input logic ov);
      seen = 1'h0;
      repeat (n) begin
         @(posedge core_clk);
         seen = seen | (exposure_out & (readout_out | !ov));
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      conclude;
   end
   initial begin
      reset_n <= 1'h0;
      avs_address <= 4'h0;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      avs_writedata <= 32'h0;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'h1;
      foreach (rows[i]) begin
         if (rows[i].w) bus(rows[i].a, 1'h1, rows[i].d, q);
         bus(rows[i].a, 1'h0, 32'h0, q);
         chk("register", q, rows[i].e);
      end
      bus(`ETC_OFS_CTRL, 1'h1, 32'h1, q);
      fork etc_trig_src_i.pulse(4); join_none
      expo(len);
      chk("single length", len, 8);
      fork etc_trig_src_i.pulse(3); join_none
      quiet(30, 1'h0);
      chk("busy trigger", {31'h0, seen}, 32'h0);
      fork etc_trig_src_i.pulse(4); join_none
      expo(len);
      chk("rearmed length", len, 8);
      quiet(30, 1'h0);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h0, q);
      etc_trig_src_i.park(1'h0);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h5, q);
      fork etc_trig_src_i.pulse(40); join_none
      expo(len);
      chk("rising length", len, 8);
      quiet(40, 1'h0);
      chk("falling edge", {31'h0, seen}, 32'h0);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h0, q);
      etc_trig_src_i.park(1'h1);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h2, q);
      fork etc_trig_src_i.pulse(20); join_none
      expo(len);
      chk("bulb length", len, 20);
      fork etc_trig_src_i.pulse(3); join_none
      quiet(30, 1'h0);
      chk("bulb busy", {31'h0, seen}, 32'h0);
      bus(`ETC_OFS_FRAMES, 1'h1, 32'h0, q);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h1, q);
      bus(`ETC_OFS_COUNT, 1'h0, 32'h0, c0);
      fork etc_trig_src_i.pulse(3); join_none
      quiet(60, 1'h1);
      chk("overlap", {31'h0, seen}, 32'h1);
      bus(`ETC_OFS_COUNT, 1'h0, 32'h0, q);
      chk("streamed", {31'h0, q - c0 > 32'h4}, 32'h1);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h0, q);
      quiet(60, 1'h0);
      bus(`ETC_OFS_FRAMES, 1'h1, 32'h2, q);
      bus(`ETC_OFS_COUNT, 1'h0, 32'h0, c0);
      bus(`ETC_OFS_CTRL, 1'h1, 32'h8, q);
      quiet(100, 1'h0);
      bus(`ETC_OFS_COUNT, 1'h0, 32'h0, q);
      chk("capture frames", q - c0, 32'h2);
      // reset in the middle of a capture must drop both indicators and the bus answer
      bus(`ETC_OFS_CTRL, 1'h1, 32'h8, q);
      quiet(6, 1'h0);
      chk("capture running", {31'h0, seen}, 32'h1);
      reset_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk("reset exposing", {31'h0, exposure_out}, 32'h0);
      chk("reset readout", {31'h0, readout_out}, 32'h0);
      chk("reset wait", {31'h0, avs_waitrequest}, 32'h1);
      reset_n <= 1'h1;
      bus(`ETC_OFS_EXPOSURE, 1'h0, 32'h0, q);
      chk("reset exposure", q, `ETC_EXPOSURE_RESET);
      quiet(20, 1'h0);
      chk("reset idle", {31'h0, seen}, 32'h0);
      conclude;
   end
endmodule
